// ==== rtl/dti_terminal_decoder.sv ====
// Purpose: Decode opto terminal inputs into drive commands
// Assumes: Inputs high when the terminal is closed
// Notes: Outputs held in flip-flops
// Notes on behaviour
// - Open trip with setting on stops, disables, logs
// - Fifteen-speed: binary code k selects preset k+1
// - All four selects closed means fault reset
// - Ramp group input open one, closed two
// - Fan-pump: enable open coasts, closed permits current
// - Two-wire forward runs while closed, stops open
// - Two-wire reverse runs while closed, stops open
// - Two-wire reference input closed selects analog one
// - Potentiometer setting forces analog one for terminal speed, unless an override is open
// - Run-source input picks keypad or terminal commands
// - Speed-source input picks keypad or terminal speed
// - Keypad to terminal keeps speed; direction is kept only in three-wire while stopped
// - First override open selects preset one
// - Second override open selects preset two
// - Both overrides open: preset one wins
// - Three-wire momentary forward closure starts forward
// - Three-wire momentary reverse closure starts reverse
// - Three-wire stop open ramps to stop
// - Keypad mode ignores all but trip
`timescale 1ns/1ps
`include "dti_consts.svh"
module dti_terminal_decoder
    import dti_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `DTI_DEBOUNCE_CYC
)(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [`DTI_NUM_IN-1:0] terminalIn,
    input wire dti_mode_t opMode,
    input wire logic extTripOn,
    input wire logic cmdSelPot,
    input wire logic keypadRun,
    input wire logic keypadReverse,
    input wire logic keypadReset,
    input wire logic [3:0] keypadPreset,
    output dti_cmd_t cmdOut,
    output dti_fault_t faultOut,
    output logic [`DTI_NUM_IN-1:0] terminalLevel
);
    localparam int CW = $clog2(DEBOUNCE_CYC + 1);
    logic [`DTI_NUM_IN-1:0] sync1_q, sync2_q, sync3_q, stable_q;
    dti_cmd_t cmd_q, cmd_d;
    dti_fault_t fault_q;
    logic tripLatch_q;
    logic run3w_q, run3w_d, rev3w_q, rev3w_d;
    logic fwdPrev_q, revPrev_q;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= terminalIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Per-input debounce counters
    genvar gi;
    generate
        for (gi = 0; gi < `DTI_NUM_IN; gi++) begin : g_deb
            logic [CW-1:0] cnt_q;
            wire agree = (sync2_q[gi] == sync3_q[gi]);
            wire differ = (sync3_q[gi] != stable_q[gi]);
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    cnt_q <= '0;
                    stable_q[gi] <= 1'b0;
                end else if (!agree || !differ) begin
                    cnt_q <= '0;
                end else if (cnt_q == CW'(DEBOUNCE_CYC - 1)) begin
                    cnt_q <= '0;
                    stable_q[gi] <= sync3_q[gi];
                end else begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
        end
    endgenerate

    wire enIn = stable_q[`DTI_IDX_ENABLE];
    wire fwdIn = stable_q[`DTI_IDX_FWD];
    wire revIn = stable_q[`DTI_IDX_REV];
    wire refIn = stable_q[`DTI_IDX_REFSRC];
    wire runSrcIn = stable_q[`DTI_IDX_RUNSRC];
    wire spdSrcIn = stable_q[`DTI_IDX_SPDSRC];
    wire ovr1In = stable_q[`DTI_IDX_OVR1];
    wire ovr2In = stable_q[`DTI_IDX_OVR2];
    wire tripIn = stable_q[`DTI_IDX_TRIP];

    wire isSpd15 = (opMode == DTI_MODE_SPD15);
    wire isFp2 = (opMode == DTI_MODE_FP2W);
    wire isFp3 = (opMode == DTI_MODE_FP3W);
    wire isFan = isFp2 || isFp3;

    wire tripNow = extTripOn && !tripIn;
    wire tripNew = tripNow && !tripLatch_q;

    // Fifteen-speed select code, first input least significant
    wire [3:0] selCode = {ovr1In, spdSrcIn, runSrcIn, refIn};
    wire spdReset = (selCode == `DTI_FAULT_RESET_CODE);
    wire [3:0] spdPreset = selCode + 4'h1;

    // Three-wire edge starts
    wire fwdRise = fwdIn && !fwdPrev_q;
    wire revRise = revIn && !revPrev_q;
    wire stop3 = !refIn;
    wire runTerm = runSrcIn;

    always_comb begin
        run3w_d = run3w_q;
        rev3w_d = rev3w_q;
        if (!isFp3 || !enIn || tripNow || stop3) begin
            run3w_d = 1'b0;
        end else if (runTerm && fwdRise) begin
            run3w_d = 1'b1;
            rev3w_d = 1'b0;
        end else if (runTerm && revRise) begin
            run3w_d = 1'b1;
            rev3w_d = 1'b1;
        end
    end

    // Fan-pump speed source, overrides first
    wire [3:0] ovrPreset = !ovr1In ? 4'h1 :
                           !ovr2In ? 4'h2 : `DTI_PRESET_NONE;
    wire fanRefAnalog = cmdSelPot || (isFp2 && refIn);
    wire dti_src_t fanTermSrc = fanRefAnalog ? DTI_SRC_ANALOG1 :
                                DTI_SRC_CMDSEL;

    always_comb begin
        cmd_d = '0;
        cmd_d.runFromTerminal = 1'b0;
        cmd_d.speedSrc = DTI_SRC_KEYPAD;
        cmd_d.presetNum = keypadPreset;
        cmd_d.driveEnable = !tripNow;
        cmd_d.runCmd = keypadRun && !tripNow;
        cmd_d.reverse = keypadReverse;
        cmd_d.faultReset = keypadReset;
        if (isSpd15) begin
            cmd_d.runFromTerminal = 1'b1;
            cmd_d.driveEnable = enIn && !tripNow;
            cmd_d.runCmd = (fwdIn ^ revIn) && enIn && !tripNow;
            cmd_d.reverse = revIn && !fwdIn;
            cmd_d.faultReset = spdReset;
            cmd_d.speedSrc = DTI_SRC_PRESET;
            cmd_d.presetNum = spdReset ? cmd_q.presetNum : spdPreset;
            cmd_d.rampGroup2 = ovr2In;
        end else if (isFan) begin
            cmd_d.runFromTerminal = runTerm;
            cmd_d.driveEnable = enIn && !tripNow;
            if (runTerm && isFp2) begin
                cmd_d.runCmd = (fwdIn ^ revIn) && enIn && !tripNow;
                cmd_d.reverse = revIn && !fwdIn;
                cmd_d.faultReset = fwdIn && revIn;
            end else if (runTerm) begin
                cmd_d.runCmd = run3w_d;
                cmd_d.reverse = run3w_d ? rev3w_d : cmd_q.reverse;
                cmd_d.faultReset = 1'b0;
            end else begin
                cmd_d.runCmd = keypadRun && enIn && !tripNow;
            end
            if (!enIn) begin
                cmd_d.runCmd = 1'b0;
            end
            if (ovrPreset != `DTI_PRESET_NONE) begin
                cmd_d.speedSrc = DTI_SRC_PRESET;
                cmd_d.presetNum = ovrPreset;
            end else if (spdSrcIn) begin
                cmd_d.speedSrc = fanTermSrc;
            end
            cmd_d.rampStop = isFp3 && stop3;
        end
        cmd_d.stopCmd = cmd_q.runCmd && !cmd_d.runCmd;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cmd_q <= '0;
            fault_q <= '0;
            tripLatch_q <= 1'b0;
            run3w_q <= 1'b0;
            rev3w_q <= 1'b0;
            fwdPrev_q <= 1'b0;
            revPrev_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            run3w_q <= run3w_d;
            rev3w_q <= rev3w_d;
            fwdPrev_q <= fwdIn;
            revPrev_q <= revIn;
            tripLatch_q <= tripNow;
            fault_q.extTrip <= tripNow;
            fault_q.faultLog <= tripNew;
        end
    end

    assign cmdOut = cmd_q;
    assign faultOut = fault_q;
    assign terminalLevel = stable_q;

    property p_trip_disable;
        @(posedge core_clk) disable iff (!rstn)
        (extTripOn && !tripIn) |=> !cmdOut.driveEnable && faultOut.extTrip;
    endproperty
    a_trip_disable: assert property (p_trip_disable)
        else $error("trip did not disable drive");

    property p_trip_log;
        @(posedge core_clk) disable iff (!rstn)
        $rose(faultOut.extTrip) |-> faultOut.faultLog;
    endproperty
    a_trip_log: assert property (p_trip_log)
        else $error("trip not logged");

    property p_spd_preset;
        @(posedge core_clk) disable iff (!rstn)
        (isSpd15 && selCode != 4'hf) |=> cmdOut.presetNum == $past(selCode) + 4'h1;
    endproperty
    a_spd_preset: assert property (p_spd_preset)
        else $error("preset code wrong");

    property p_spd_reset;
        @(posedge core_clk) disable iff (!rstn)
        (isSpd15 && selCode == 4'hf) |=> cmdOut.faultReset;
    endproperty
    a_spd_reset: assert property (p_spd_reset)
        else $error("fault reset missed");

    property p_ramp_grp;
        @(posedge core_clk) disable iff (!rstn)
        isSpd15 |=> cmdOut.rampGroup2 == $past(ovr2In);
    endproperty
    a_ramp_grp: assert property (p_ramp_grp)
        else $error("ramp group wrong");

    property p_enable;
        @(posedge core_clk) disable iff (!rstn)
        (isFan && !enIn) |=> !cmdOut.driveEnable && !cmdOut.runCmd;
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable open still drives");

    property p_ovr1;
        @(posedge core_clk) disable iff (!rstn)
        (isFan && !ovr1In) |=> cmdOut.presetNum == 4'h1
            && cmdOut.speedSrc == DTI_SRC_PRESET;
    endproperty
    a_ovr1: assert property (p_ovr1)
        else $error("override one not taken");

    property p_ovr2;
        @(posedge core_clk) disable iff (!rstn)
        (isFan && ovr1In && !ovr2In) |=> cmdOut.presetNum == 4'h2;
    endproperty
    a_ovr2: assert property (p_ovr2)
        else $error("override two not taken");

    property p_pot;
        @(posedge core_clk) disable iff (!rstn)
        (isFan && cmdSelPot && spdSrcIn && ovr1In && ovr2In)
            |=> cmdOut.speedSrc == DTI_SRC_ANALOG1;
    endproperty
    a_pot: assert property (p_pot)
        else $error("pot not forcing analog one");

    property p_latch3;
        @(posedge core_clk) disable iff (!rstn)
        (isFp3 && run3w_q && !stop3 && enIn && !tripNow) |=> run3w_q;
    endproperty
    a_latch3: assert property (p_latch3)
        else $error("three-wire run dropped");

    property p_stop3;
        @(posedge core_clk) disable iff (!rstn)
        (isFp3 && stop3) |=> !cmdOut.runCmd ##0 cmdOut.rampStop;
    endproperty
    a_stop3: assert property (p_stop3)
        else $error("stop input ignored");

    property p_fwd2w;
        @(posedge core_clk) disable iff (!rstn)
        (isFp2 && runTerm && enIn && !tripNow && fwdIn && !revIn)
            |=> cmdOut.runCmd && !cmdOut.reverse;
    endproperty
    a_fwd2w: assert property (p_fwd2w)
        else $error("two-wire forward not running");

    property p_rev2w;
        @(posedge core_clk) disable iff (!rstn)
        (isFp2 && runTerm && enIn && !tripNow && revIn && !fwdIn)
            |=> cmdOut.runCmd && cmdOut.reverse;
    endproperty
    a_rev2w: assert property (p_rev2w)
        else $error("two-wire reverse not running");

    property p_open2w;
        @(posedge core_clk) disable iff (!rstn)
        (isFp2 && runTerm && !fwdIn && !revIn) |=> !cmdOut.runCmd;
    endproperty
    a_open2w: assert property (p_open2w)
        else $error("two-wire open still running");

    property p_stop_pulse;
        @(posedge core_clk) disable iff (!rstn)
        $fell(cmdOut.runCmd) |-> cmdOut.stopCmd;
    endproperty
    a_stop_pulse: assert property (p_stop_pulse)
        else $error("stop command missing");

    property p_run_src;
        @(posedge core_clk) disable iff (!rstn)
        (isFan && !runTerm) |=> !cmdOut.runFromTerminal
            && cmdOut.faultReset == $past(keypadReset);
    endproperty
    a_run_src: assert property (p_run_src)
        else $error("run source not keypad");

    property p_spd_src;
        @(posedge core_clk) disable iff (!rstn)
        (isFan && !spdSrcIn && ovr1In && ovr2In)
            |=> cmdOut.speedSrc == DTI_SRC_KEYPAD;
    endproperty
    a_spd_src: assert property (p_spd_src)
        else $error("speed source not keypad");

    property p_start3f;
        @(posedge core_clk) disable iff (!rstn)
        (isFp3 && runTerm && enIn && !tripNow && !stop3 && fwdRise)
            |=> cmdOut.runCmd && !cmdOut.reverse;
    endproperty
    a_start3f: assert property (p_start3f)
        else $error("three-wire forward start missed");

    property p_start3r;
        @(posedge core_clk) disable iff (!rstn)
        (isFp3 && runTerm && enIn && !tripNow && !stop3
            && revRise && !fwdRise) |=> cmdOut.runCmd && cmdOut.reverse;
    endproperty
    a_start3r: assert property (p_start3r)
        else $error("three-wire reverse start missed");

    property p_keypad;
        @(posedge core_clk) disable iff (!rstn)
        (opMode == DTI_MODE_KEYPAD && !tripNow)
            |=> cmdOut.runCmd == $past(keypadRun)
            && cmdOut.reverse == $past(keypadReverse);
    endproperty
    a_keypad: assert property (p_keypad)
        else $error("keypad mode not following keypad");
endmodule

// ==== pkg/dti_consts.svh ====
// Purpose: Constants for the terminal input decoder
// Assumes: 40 MHz core clock
// Notes: Times in microseconds, counts derived
`ifndef DTI_CONSTS_SVH
`define DTI_CONSTS_SVH
`define DTI_CLK_MHZ 40
`define DTI_DEBOUNCE_US 1000
`define DTI_DEBOUNCE_CYC (`DTI_DEBOUNCE_US * `DTI_CLK_MHZ)
`define DTI_NUM_IN 9
`define DTI_IDX_ENABLE 0
`define DTI_IDX_FWD 1
`define DTI_IDX_REV 2
`define DTI_IDX_REFSRC 3
`define DTI_IDX_RUNSRC 4
`define DTI_IDX_SPDSRC 5
`define DTI_IDX_OVR1 6
`define DTI_IDX_OVR2 7
`define DTI_IDX_TRIP 8
`define DTI_FAULT_RESET_CODE 4'hf
`define DTI_PRESET_NONE 4'h0
`endif

// ==== pkg/dti_pkg.sv ====
// Purpose: Types for the terminal input decoder
// Assumes: Constants header alongside
// Notes: Mode and source enumerations
package dti_pkg;
    typedef enum logic [2:0] {
        DTI_MODE_KEYPAD,
        DTI_MODE_STD3W,
        DTI_MODE_SPD15,
        DTI_MODE_FP2W,
        DTI_MODE_FP3W,
        DTI_MODE_OTHER
    } dti_mode_t;
    typedef enum logic [1:0] {
        DTI_SRC_KEYPAD,
        DTI_SRC_ANALOG1,
        DTI_SRC_CMDSEL,
        DTI_SRC_PRESET
    } dti_src_t;
    typedef enum logic [1:0] {
        DTI_DIR_STOP,
        DTI_DIR_FWD,
        DTI_DIR_REV
    } dti_dir_t;
    typedef struct packed {
        logic runCmd;
        logic reverse;
        logic driveEnable;
        logic rampStop;
        logic stopCmd;
        logic faultReset;
        logic rampGroup2;
        logic runFromTerminal;
        logic [3:0] presetNum;
        dti_src_t speedSrc;
    } dti_cmd_t;
    typedef struct packed {
        logic extTrip;
        logic faultLog;
    } dti_fault_t;
endpackage

// ==== sim/dti_switch_bank.sv ====
// Purpose: Model of external switches on the opto inputs
// Assumes: 1 = closed, contacts bounce after each change
// Notes: Bounce is shorter than the debounce span
`timescale 1ns/1ps
module dti_switch_bank (
    input wire logic core_clk,
    input wire logic [8:0] want,
    input wire logic tripWired,
    output logic [8:0] terminalIn
);
    logic [8:0] last_q = '0;
    logic [8:0] chg_q = '0;
    logic [1:0] cnt_q = '0;
    logic [8:0] lvl;
    always @(posedge core_clk) begin
        last_q <= want;
        if (want != last_q) begin
            chg_q <= want ^ last_q;
            cnt_q <= 2'h3;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
    // Contacts chatter between old and new level
    assign lvl = want ^ (chg_q & {9{cnt_q[0]}});
    // Unwired trip terminal reads open
    assign terminalIn = {tripWired & lvl[8], lvl[7:0]};
endmodule

// ==== sim/drive_terminal_input_decoder_bench.sv ====
// Purpose: Self-checking bench for the terminal decoder
// Assumes: Short debounce count in simulation
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module drive_terminal_input_decoder_bench
    import dti_pkg::*;
;
    localparam logic [8:0] EN = 9'h001, FW = 9'h002, RV = 9'h004;
    localparam logic [8:0] B3 = 9'h008, RS = 9'h010, SS = 9'h020;
    localparam logic [8:0] O1 = 9'h040, O2 = 9'h080, BS = 9'h1F1;
    logic core_clk = 1'b0;
    logic rstn;
    logic [8:0] want;
    logic [8:0] terminalIn;
    logic [8:0] terminalLevel;
    dti_mode_t opMode;
    logic extTripOn, cmdSelPot, keypadRun, keypadReverse;
    logic keypadReset;
    dti_cmd_t cmdOut;
    dti_fault_t faultOut;
    int n_mismatch = 0;
    int checked = 0;
    int nStop = 0;
    int nLog = 0;
    int baseStop;
    int baseLog;
    dti_terminal_decoder #(.DEBOUNCE_CYC(4)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .terminalIn(terminalIn),
        .opMode(opMode), .extTripOn(extTripOn), .cmdSelPot(cmdSelPot),
        .keypadRun(keypadRun), .keypadReverse(keypadReverse),
        .keypadReset(keypadReset), .keypadPreset(4'h3), .cmdOut(cmdOut),
        .faultOut(faultOut), .terminalLevel(terminalLevel));
    dti_switch_bank i_sw (.core_clk(core_clk), .want(want),
        .tripWired(extTripOn), .terminalIn(terminalIn));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // Count one-cycle pulses while they stand
    always @(negedge core_clk) begin
        if (cmdOut.stopCmd === 1'b1) begin
            nStop++;
        end
        if (faultOut.faultLog === 1'b1) begin
            nLog++;
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Drive switches, wait for debounced level, then two more cycles
    task automatic apply(input logic [8:0] w);
        int i;
        @(negedge core_clk);
        want = w;
        for (i = 0; terminalLevel !== {extTripOn & w[8], w[7:0]}; i++) begin
            if (i > 60) begin
                n_mismatch++;
                final_report();
            end
            @(negedge core_clk);
        end
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rv(input logic [7:0] r, v);
        chk("run", 8'(cmdOut.runCmd), r);
        chk("reverse", 8'(cmdOut.reverse), v);
    endtask
    task automatic src(input dti_src_t s);
        chk("speedSrc", 8'(cmdOut.speedSrc), 8'(s));
    endtask
    initial begin
        rstn = 1'b0;
        want = '0;
        opMode = DTI_MODE_SPD15;
        extTripOn = 1'b1;
        cmdSelPot = 1'b0;
        keypadRun = 1'b0;
        keypadReverse = 1'b0;
        keypadReset = 1'b0;
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        for (int k = 0; k < 16; k++) begin
            apply({1'b1, k[0], k[3:0], 3'b001});
            if (k < 15)
                chk("preset", 8'(cmdOut.presetNum), 8'(k + 1));
            else
                chk("faultReset", 8'(cmdOut.faultReset), 8'h01);
            chk("ramp", 8'(cmdOut.rampGroup2), 8'(k[0]));
        end
        $display("preset decode done");
        apply(9'h103);
        rv(1, 0);
        baseStop = nStop;
        baseLog = nLog;
        apply(EN | FW);
        chk("trip", 8'(faultOut.extTrip), 8'h01);
        chk("enable", 8'(cmdOut.driveEnable), 8'h00);
        rv(0, 0);
        chk("stopCmd", 8'(nStop - baseStop), 8'h01);
        chk("faultLog", 8'(nLog - baseLog), 8'h01);
        extTripOn = 1'b0;
        apply(EN);
        chk("trip", 8'(faultOut.extTrip), 8'h00);
        extTripOn = 1'b1;
        $display("trip done");
        opMode = DTI_MODE_FP2W;
        apply(BS | FW);
        rv(1, 0);
        chk("enable", 8'(cmdOut.driveEnable), 8'h01);
        baseStop = nStop;
        apply(BS);
        rv(0, 0);
        chk("stopCmd", 8'(nStop - baseStop), 8'h01);
        apply(BS | RV);
        rv(1, 1);
        apply(BS ^ EN | RV);
        chk("enable", 8'(cmdOut.driveEnable), 8'h00);
        apply(BS | B3);
        src(DTI_SRC_ANALOG1);
        apply(BS);
        src(DTI_SRC_CMDSEL);
        cmdSelPot = 1'b1;
        apply(BS);
        src(DTI_SRC_ANALOG1);
        cmdSelPot = 1'b0;
        apply(BS ^ SS);
        src(DTI_SRC_KEYPAD);
        apply(BS ^ O1);
        src(DTI_SRC_PRESET);
        chk("preset", 8'(cmdOut.presetNum), 8'h01);
        apply(BS ^ O2);
        chk("preset", 8'(cmdOut.presetNum), 8'h02);
        apply(BS ^ O1 ^ O2);
        chk("preset", 8'(cmdOut.presetNum), 8'h01);
        keypadRun = 1'b1;
        apply(BS ^ RS | FW);
        chk("fromTerm", 8'(cmdOut.runFromTerminal), 8'h00);
        rv(1, 0);
        keypadReset = 1'b1;
        apply(BS ^ RS | FW);
        chk("faultReset", 8'(cmdOut.faultReset), 8'h01);
        apply(BS | FW);
        chk("fromTerm", 8'(cmdOut.runFromTerminal), 8'h01);
        rv(1, 0);
        chk("faultReset", 8'(cmdOut.faultReset), 8'h00);
        keypadReset = 1'b0;
        apply(BS | FW | RV);
        chk("faultReset", 8'(cmdOut.faultReset), 8'h01);
        rv(0, 0);
        keypadRun = 1'b0;
        $display("fan pump two-wire done");
        opMode = DTI_MODE_FP3W;
        apply(BS | B3);
        rv(0, 0);
        apply(BS | B3 | FW);
        apply(BS | B3);
        rv(1, 0);
        apply(BS);
        rv(0, 0);
        chk("rampStop", 8'(cmdOut.rampStop), 8'h01);
        apply(BS | B3 | RV);
        apply(BS | B3);
        rv(1, 1);
        chk("rampStop", 8'(cmdOut.rampStop), 8'h00);
        apply(BS ^ EN | B3);
        rv(0, 1);
        $display("fan pump three-wire done");
        opMode = DTI_MODE_KEYPAD;
        apply(BS | B3 | FW);
        rv(0, 0);
        keypadRun = 1'b1;
        keypadReverse = 1'b1;
        apply(BS | B3 | FW);
        rv(1, 1);
        apply(BS ^ EN | B3);
        rv(1, 1);
        chk("enable", 8'(cmdOut.driveEnable), 8'h01);
        baseLog = nLog;
        apply(BS ^ 9'h100 | B3);
        chk("trip", 8'(faultOut.extTrip), 8'h01);
        rv(0, 1);
        chk("faultLog", 8'(nLog - baseLog), 8'h01);
        $display("keypad done");
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("reset", 8'(|{cmdOut, faultOut, terminalLevel}), 8'h00);
        rstn = 1'b1;
        apply(BS | B3);
        rv(1, 1);
        $display("reset done");
        final_report();
    end
endmodule
